// [core/dcc_master_end.sv]
`timescale 1ns/100ps
module dcc_master_end (
  input  wire logic        clk,         // Clock
  input  wire logic        srst,        // Synchronous reset
  dcc_link_if.master       lnk,         // Link to slave
  input  wire logic  [7:0] cmdPoly,     // Command check polynomial
  input  wire logic  [7:0] rspPoly,     // Response check polynomial
  input  wire logic [23:0] cmdMsg,      // Address, opcode, upper, lower
  input  wire logic        cmdValid,    // Command offered
  output logic             cmdReady,    // Command queue has room
  output logic      [23:0] rspMsg,      // Received response message
  output logic       [7:0] rspCrc,      // Received response check
  output logic             rspValid,    // Pulse: response complete
  output logic             rspCrcOk,    // Response check remainder zero
  output logic             rspSymErr,   // An illegal symbol was seen
  output logic             rspTimeout   // Pulse: no response came
);
  import dcc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_WAIT = 2'b10,
    HS_RECV = 2'b11
  } dcc_host_st_t;

  typedef struct packed {
    dcc_host_st_t st;
    logic [31:0]  sh;
    logic [5:0]   cnt;
    logic [3:0]   div;
    logic [9:0]   wait_;
    logic [1:0]   chip;
    logic [2:0]   nib;
    logic [5:0]   chips;
    logic         bitOut;
    logic         bitStb;
    logic         sof;
    logic [23:0]  rspMsg;
    logic [7:0]   rspCrc;
    logic         rspValid;
    logic         crcOk;
    logic         symErr;
    logic         timeout;
  } dcc_host_state_t;

  dcc_host_state_t q, n;
  logic [23:0]     qMsg;
  logic            qValid;
  logic            qPop;
  logic [3:0]      dec;
  logic            hit;

  dcc_fifo #(.W(MSG_W), .D(8)) dcc_fifo_inst (
    .clk      (clk),
    .srst     (srst),
    .inData   (cmdMsg),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .outData  (qMsg),
    .outValid (qValid),
    .outReady (qPop)
  );

  // Queue drains only between transactions, so it back-pressures the user
  assign qPop = (q.st == HS_IDLE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    dec        = '0;
    hit        = 1'b0;
    n          = q;
    n.bitStb   = 1'b0;
    n.sof      = 1'b0;
    n.rspValid = 1'b0;
    n.timeout  = 1'b0;
    case (q.st)
      HS_IDLE: begin
        if (qValid) begin
          n.sh  = {qMsg, dcc_crc_run({qMsg, 8'h00}, cmdPoly)};
          n.cnt = '0;
          n.div = '0;
          n.st  = HS_SEND;
        end
      end
      HS_SEND: begin
        if (q.div == 4'h0 && q.cnt != FRM_CNT) begin
          n.bitStb = 1'b1;
          n.bitOut = q.sh[FRM_W-1];
          n.sof    = (q.cnt == 6'h00);
          n.sh     = {q.sh[FRM_W-2:0], 1'b0};
          n.cnt    = q.cnt + 6'h01;
        end
        n.div = (q.div == BIT_LAST) ? 4'h0 : q.div + 4'h1;
        // Listen right after the last strobe: the slave answers within a few
        // cycles, and waiting out the bit period would miss the first chip
        if (q.cnt == FRM_CNT) begin
          n.wait_ = '0;
          n.st    = HS_WAIT;
        end
      end
      HS_WAIT: begin
        n.wait_ = q.wait_ + 10'h001;
        if (lnk.rspActive) begin
          n.div    = 4'h1;
          n.chip   = '0;
          n.nib    = '0;
          n.symErr = 1'b0;
          n.st     = HS_RECV;
        end else if (q.wait_ == WAIT_LAST) begin
          n.timeout = 1'b1;
          n.st      = HS_IDLE;
        end
      end
      HS_RECV: begin
        n.div = q.div + 4'h1;
        if (q.div == CHIP_MID) begin
          n.chips = {q.chips[3:0], 2'(lnk.rspLevel)};
        end
        if (q.div == CHIP_LAST) begin
          n.div  = '0;
          n.chip = q.chip + 2'h1;
          if (q.chip == CHIP_END) begin
            n.chip = '0;
            for (int i = 0; i < 16; i++) begin
              if (SYM_TAB[i] == q.chips) begin
                dec = 4'(i);
                hit = 1'b1;
              end
            end
            n.symErr = q.symErr | !hit;
            n.sh     = {q.sh[FRM_W-5:0], dec};
            n.nib    = q.nib + 3'h1;
            if (q.nib == NIB_LAST) begin
              n.rspMsg   = n.sh[FRM_W-1:CRC_W];
              n.rspCrc   = n.sh[CRC_W-1:0];
              n.crcOk    = (dcc_crc_run(n.sh, rspPoly) == 8'h00);
              n.rspValid = 1'b1;
              n.st       = HS_IDLE;
            end
          end
        end
      end
      default: begin
        n.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q    <= '0;
      q.st <= HS_IDLE;
    end else begin
      q <= n;
    end
  end

  assign lnk.cmdBit    = q.bitOut;
  assign lnk.cmdBitStb = q.bitStb;
  assign lnk.cmdSof    = q.sof;
  assign rspMsg        = q.rspMsg;
  assign rspCrc        = q.rspCrc;
  assign rspValid      = q.rspValid;
  assign rspCrcOk      = q.crcOk;
  assign rspSymErr     = q.symErr;
  assign rspTimeout    = q.timeout;
endmodule : dcc_master_end

// [core/dcc_pkg.sv]
package dcc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 4;
  localparam int BIT_NS       = 32;
  localparam int CHIP_NS      = 32;
  localparam int RSP_WAIT_NS  = 2048;
  localparam int BIT_CYC      = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CHIP_CYC     = (CHIP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSP_WAIT_CYC = RSP_WAIT_NS / CLK_NS;
  localparam logic [3:0] BIT_LAST  = 4'(BIT_CYC - 1);
  localparam logic [3:0] CHIP_LAST = 4'(CHIP_CYC - 1);
  localparam logic [3:0] CHIP_MID  = 4'(CHIP_CYC / 2);
  localparam logic [9:0] WAIT_LAST = 10'(RSP_WAIT_CYC - 1);

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int MSG_W     = 24;
  localparam int CRC_W     = 8;
  localparam int FRM_W     = 32;
  localparam int ADDR_LSB  = 20;
  localparam int OPC_LSB   = 16;
  localparam int UPPER_LSB = 8;
  localparam int LOWER_LSB = 0;
  localparam logic [5:0] FRM_CNT  = 6'(FRM_W);
  localparam logic [2:0] NIB_LAST = 3'h7;
  localparam logic [1:0] CHIP_END = 2'h2;
  localparam logic [7:0] CRC_POLY_RST = 8'h2F;
  localparam logic [7:0] CRC_SEED     = 8'hFF;
  localparam logic [3:0] OPC_READ     = 4'h0;
  localparam logic [3:0] OPC_WRITE    = 4'h8;

  typedef enum logic [1:0] {
    LVL_IDLE = 2'b00,
    LVL_ONE  = 2'b01,
    LVL_TWO  = 2'b10
  } dcc_lvl_t;

  // Symbol per nibble, chips first to last, two bits each; entry 0 rightmost
  localparam logic [15:0][5:0] SYM_TAB = {
    6'h19, 6'h11, 6'h20, 6'h18, 6'h29, 6'h1A, 6'h24, 6'h28,
    6'h21, 6'h16, 6'h26, 6'h10, 6'h22, 6'h12, 6'h25, 6'h14};

  function automatic logic [7:0] dcc_crc_step(logic [7:0] crc, logic din,
                                              logic [7:0] poly);
    dcc_crc_step = {crc[6:0], din} ^ (crc[7] ? poly : 8'h00);
  endfunction : dcc_crc_step

  function automatic logic [7:0] dcc_crc_run(logic [31:0] bits, logic [7:0] poly);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = FRM_W - 1; i >= 0; i--) begin
      c = dcc_crc_step(c, bits[i], poly);
    end
    dcc_crc_run = c;
  endfunction : dcc_crc_run
endpackage : dcc_pkg

// [core/dcc_link_if.sv]
`timescale 1ns/100ps
interface dcc_link_if (
  input wire logic clk  // Common clock
);
  import dcc_pkg::*;
  logic     cmdBit;     // Command bit, MSB first
  logic     cmdBitStb;  // One-cycle strobe per command bit
  logic     cmdSof;     // With the strobe of a frame's first bit
  dcc_lvl_t rspLevel;   // Response chip current level
  logic     rspActive;  // High for the whole response

  modport master (input clk, output cmdBit, cmdBitStb, cmdSof, input rspLevel, rspActive);
  modport slave  (input clk, input cmdBit, cmdBitStb, cmdSof, output rspLevel, rspActive);
endinterface : dcc_link_if

// [core/dcc_fifo.sv]
`timescale 1ns/100ps
module dcc_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input  wire logic         clk,       // Clock
  input  wire logic         srst,      // Synchronous reset
  input  wire logic [W-1:0] inData,    // Write data
  input  wire logic         inValid,   // Write request
  output logic              inReady,   // Not full
  output logic      [W-1:0] outData,   // Head word
  output logic              outValid,  // Not empty
  input  wire logic         outReady   // Pop
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } dcc_fifo_state_t;

  dcc_fifo_state_t q, n;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  assign inReady  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
  assign outValid = (q.wp != q.rp);
  assign outData  = mem[q.rp[AW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    n = q;
    if (push) begin
      n.wp = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
    if (push) begin
      mem[q.wp[AW-1:0]] <= inData;
    end
  end
endmodule : dcc_fifo

// [core/dcc_slave_end.sv]
`timescale 1ns/100ps
module dcc_slave_end (
  input  wire logic       clk,          // Clock
  input  wire logic       srst,         // Synchronous reset
  dcc_link_if.slave       lnk,          // Link to master
  input  wire logic [3:0] nodeNumber,   // Node number register value
  input  wire logic [7:0] cmdPoly,      // Command check polynomial
  input  wire logic [7:0] rspPoly,      // Response check polynomial
  output logic      [7:0] regAddr,      // Requested byte address
  output logic      [7:0] regAddrNext,  // Requested address plus one
  input  wire logic [7:0] regLow,       // Data at regAddr
  input  wire logic [7:0] regHigh,      // Data at regAddrNext
  output logic            wrStb,        // Register write pulse
  output logic      [7:0] wrData,       // Register write data
  output logic            cmdDrop,      // Pulse: command failed check
  output logic            busy          // Not listening for commands
);
  import dcc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DS_RX    = 2'b00,
    DS_EXEC  = 2'b01,
    DS_FETCH = 2'b10,
    DS_TX    = 2'b11
  } dcc_dev_st_t;

  // Everything this end remembers, registered as one word
  typedef struct packed {
    dcc_dev_st_t st;
    logic [31:0] rxSh;
    logic [5:0]  rxCnt;
    logic [7:0]  rxCrc;
    logic        rxOn;
    logic [3:0]  opc;
    logic [7:0]  regAddr;
    logic [7:0]  regAddrNext;
    logic        wrStb;
    logic [7:0]  wrData;
    logic        cmdDrop;
    logic [31:0] txSh;
    logic [2:0]  nibCnt;
    logic [1:0]  chipCnt;
    logic [3:0]  divCnt;
    dcc_lvl_t    level;
    logic        active;
  } dcc_dev_state_t;

  dcc_dev_state_t q, n;
  // Combinational scratch, all defaulted at the top of the process
  logic [7:0]     crcNext;
  logic [23:0]    msgRx;
  logic [23:0]    msgTx;
  logic [5:0]     sym;

  // ----------------------------------------------------------------
  // Chip of a symbol
  // ----------------------------------------------------------------
  // First chip sits in the top bits so a table entry reads left to right
  function automatic dcc_lvl_t chip_of(logic [5:0] s, logic [1:0] idx);
    logic [1:0] c;
    case (idx)
      2'h0:    c = s[5:4];
      2'h1:    c = s[3:2];
      default: c = s[1:0];
    endcase
    chip_of = dcc_lvl_t'(c);
  endfunction : chip_of

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    crcNext   = '0;
    msgRx     = '0;
    msgTx     = '0;
    sym       = '0;
    n         = q;
    n.wrStb   = 1'b0;
    n.cmdDrop = 1'b0;
    case (q.st)
      DS_RX: begin
        // A strobe without start of frame while idle is stray and ignored
        if (lnk.cmdBitStb && (lnk.cmdSof || q.rxOn)) begin
          // The start-of-frame strobe seeds the check itself, so a fresh frame
          // after a cut one never inherits stale check bits
          crcNext = dcc_crc_step(lnk.cmdSof ? CRC_SEED : q.rxCrc, lnk.cmdBit, cmdPoly);
          n.rxCrc = crcNext;
          n.rxSh  = {q.rxSh[FRM_W-2:0], lnk.cmdBit};
          // Counting restarts on every frame start; a cut frame is simply lost
          n.rxCnt = lnk.cmdSof ? 6'h01 : q.rxCnt + 6'h01;
          n.rxOn  = 1'b1;
          if (n.rxCnt == FRM_CNT) begin
            n.rxOn = 1'b0;
            msgRx  = n.rxSh[FRM_W-1:CRC_W];
            if (crcNext != 8'h00) begin
              n.cmdDrop = 1'b1;
            end else if (msgRx[ADDR_LSB+:4] == nodeNumber) begin
              // Unimplemented opcodes get no response
              if (msgRx[OPC_LSB+:4] == OPC_READ || msgRx[OPC_LSB+:4] == OPC_WRITE) begin
                n.opc         = msgRx[OPC_LSB+:4];
                n.regAddr     = msgRx[UPPER_LSB+:8];
                n.regAddrNext = msgRx[UPPER_LSB+:8] + 8'h01;
                n.wrData      = msgRx[LOWER_LSB+:8];
                n.wrStb       = (msgRx[OPC_LSB+:4] == OPC_WRITE);
                n.st          = DS_EXEC;
              end
            end
          end
        end
      end
      DS_EXEC: begin
        // One cycle so the write is seen by the read-back
        n.st = DS_FETCH;
      end
      DS_FETCH: begin
        // Read data is taken here, one cycle after the address settles; the
        // register file must answer combinationally within that cycle, and a
        // write from the previous cycle is already visible
        msgTx     = {nodeNumber, q.opc, regHigh, regLow};
        crcNext   = dcc_crc_run({msgTx, 8'h00}, rspPoly);
        n.txSh    = {msgTx, crcNext};
        n.nibCnt  = '0;
        n.chipCnt = '0;
        n.divCnt  = '0;
        n.active  = 1'b1;
        sym       = SYM_TAB[n.txSh[FRM_W-1-:4]];
        n.level   = chip_of(sym, 2'h0);
        n.st      = DS_TX;
      end
      DS_TX: begin
        // One chip lasts CHIP_CYC clocks; the divider wraps at CHIP_LAST
        n.divCnt = q.divCnt + 4'h1;
        if (q.divCnt == CHIP_LAST) begin
          n.divCnt = '0;
          if (q.chipCnt == CHIP_END) begin
            n.chipCnt = '0;
            if (q.nibCnt == NIB_LAST) begin
              n.active = 1'b0;
              n.level  = LVL_IDLE;
              n.st     = DS_RX;
            end else begin
              n.nibCnt = q.nibCnt + 3'h1;
              n.txSh   = {q.txSh[FRM_W-5:0], 4'h0};
              sym      = SYM_TAB[n.txSh[FRM_W-1-:4]];
              n.level  = chip_of(sym, 2'h0);
            end
          end else begin
            n.chipCnt = q.chipCnt + 2'h1;
            sym       = SYM_TAB[q.txSh[FRM_W-1-:4]];
            n.level   = chip_of(sym, n.chipCnt);
          end
        end
      end
      default: begin
        n.st = DS_RX;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      q       <= '0;
      // State and level are spelled out although their codes are zero, so a
      // change of encoding cannot leave the current non-idle after reset
      q.st    <= DS_RX;
      q.level <= LVL_IDLE;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign lnk.rspLevel  = q.level;
  assign lnk.rspActive = q.active;
  assign regAddr       = q.regAddr;
  assign regAddrNext   = q.regAddrNext;
  // The write pulse lasts one cycle; the register file must take it then
  assign wrStb         = q.wrStb;
  assign wrData        = q.wrData;
  // A dropped frame leaves no other trace than this pulse
  assign cmdDrop       = q.cmdDrop;
  // Command bits that arrive while busy are lost, not queued
  assign busy          = (q.st != DS_RX);
endmodule : dcc_slave_end

// [verification/dcc_link_checker.sv]
`timescale 1ns/100ps
module dcc_link_checker (
  input wire logic              clk,        // Clock
  input wire logic              srst,       // Synchronous reset
  input wire logic              cmdBitStb,  // Command bit strobe
  input wire logic              cmdSof,     // Frame start
  input wire dcc_pkg::dcc_lvl_t rspLevel,   // Response chip level
  input wire logic              rspActive   // Response in flight
);
  import dcc_pkg::*;
  logic [5:0] bitCnt_q;
  logic [7:0] actCnt_q;

  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      bitCnt_q <= 6'h00;
      actCnt_q <= 8'h00;
    end else begin
      if (cmdSof) bitCnt_q <= 6'h01;
      else if (cmdBitStb) bitCnt_q <= bitCnt_q + 6'h01;
      actCnt_q <= rspActive ? actCnt_q + 8'h01 : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Link properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sof_with_strobe_a: assert property (cmdSof |-> cmdBitStb)
    else $error("Frame start without bit strobe");
  frame_bit_count_a: assert property (cmdSof |-> bitCnt_q == 6'h00 || bitCnt_q == 6'h20)
    else $error("Frame restarted before 32 bits");
  bits_in_frame_a: assert property (cmdBitStb && !cmdSof |-> bitCnt_q inside {[6'h01:6'h1F]})
    else $error("Bit strobe outside a frame");
  bit_spacing_a: assert property (cmdBitStb |=> !cmdBitStb [*7])
    else $error("Bit strobes closer than one bit time");
  rsp_length_a: assert property (!$past(srst) && $fell(rspActive) |-> actCnt_q == 8'hC0)
    else $error("Response not 24 chips long");
  rsp_bounded_a: assert property (rspActive |-> actCnt_q < 8'hC0)
    else $error("Response longer than 24 chips");
  idle_outside_a: assert property (!rspActive |-> rspLevel == LVL_IDLE)
    else $error("Current level outside a response");
  legal_level_a: assert property (rspActive |-> rspLevel inside {LVL_IDLE, LVL_ONE, LVL_TWO})
    else $error("Illegal chip level");
  chip_steady_a: assert property (rspActive && actCnt_q[2:0] != 3'h0 |-> $stable(rspLevel))
    else $error("Level changed inside a chip");
  symbol_start_a: assert property (rspActive && (actCnt_q % 8'h18) == 8'h00 |-> rspLevel != LVL_IDLE)
    else $error("Symbol starts at idle level");
  symbol_varies_a: assert property (rspActive && (actCnt_q % 8'h18) == 8'h00 |-> ##16
    !(rspLevel == $past(rspLevel, 8) && rspLevel == $past(rspLevel, 16)))
    else $error("Symbol without transition");
  rsp_after_cmd_a: assert property ($rose(rspActive) |-> $past(cmdBitStb, 3))
    else $error("Response start not tied to last command bit");
  quiet_while_rsp_a: assert property (rspActive |-> !cmdBitStb)
    else $error("Command bits during a response");
endmodule : dcc_link_checker

// [verification/dsi3_crm_frame_codec_tb.sv]
`timescale 1ns/100ps
module dsi3_crm_frame_codec_tb;
  import dcc_pkg::*;
  // ------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------
  logic        clk;
  logic        srst;
  logic [3:0]  nodeNumber;
  logic [7:0]  mPoly;
  logic [7:0]  sPoly;
  logic [7:0]  rPoly;
  logic [23:0] cmdMsg;
  logic        cmdValid;
  logic        cmdReady;
  logic [23:0] rspMsg;
  logic [7:0]  rspCrc;
  logic        rspValid;
  logic        rspCrcOk;
  logic        rspSymErr;
  logic        rspTimeout;
  logic [7:0]  regAddr;
  logic [7:0]  regAddrNext;
  logic        wrStb;
  logic [7:0]  wrData;
  logic        cmdDrop;
  logic        busy;
  int          errorCnt;
  int          comparisons;
  int          act = 0;
  dcc_lvl_t    chips[$];
  // Three chip levels per nibble, nibble 0 first
  localparam string SYMS = "110211102202100212112201220210122221120200101121";

  // Register file stand-in: contents are a fixed function of the address
  function automatic logic [7:0] memAt(logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'hC3;
  endfunction : memAt

  function automatic logic [7:0] crcOf(logic [31:0] fr, logic [7:0] p);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 31; i >= 0; i--) c = {c[6:0], fr[i]} ^ (c[7] ? p : 8'h00);
    return c;
  endfunction : crcOf

  dcc_link_if dcc_link_if_inst (.clk(clk));
  dcc_master_end dcc_master_end_inst (.clk(clk), .srst(srst), .lnk(dcc_link_if_inst),
    .cmdPoly(mPoly), .rspPoly(rPoly), .cmdMsg(cmdMsg), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .rspMsg(rspMsg), .rspCrc(rspCrc), .rspValid(rspValid),
    .rspCrcOk(rspCrcOk), .rspSymErr(rspSymErr), .rspTimeout(rspTimeout));
  dcc_slave_end dcc_slave_end_inst (.clk(clk), .srst(srst), .lnk(dcc_link_if_inst),
    .nodeNumber(nodeNumber), .cmdPoly(sPoly), .rspPoly(rPoly), .regAddr(regAddr),
    .regAddrNext(regAddrNext), .regLow(memAt(regAddr)), .regHigh(memAt(regAddrNext)),
    .wrStb(wrStb), .wrData(wrData), .cmdDrop(cmdDrop), .busy(busy));
  dcc_link_checker dcc_link_checker_inst (.clk(clk), .srst(srst),
    .cmdBitStb(dcc_link_if_inst.cmdBitStb), .cmdSof(dcc_link_if_inst.cmdSof),
    .rspLevel(dcc_link_if_inst.rspLevel), .rspActive(dcc_link_if_inst.rspActive));

  // Mid-chip sample of every response chip
  always @(negedge clk) begin
    if (dcc_link_if_inst.rspActive === 1'b1) begin
      if (act % 8 == 3) chips.push_back(dcc_link_if_inst.rspLevel);
      act++;
    end else begin
      act = 0;
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic endSim();
    $display("Comparisons %0d, mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : endSim

  task automatic send(logic [23:0] m);
    chips.delete();
    @(negedge clk);
    cmdMsg = m;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
  endtask : send

  task automatic waitResp(output logic got);
    got = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (rspValid === 1'b1 || rspTimeout === 1'b1) begin
        got = rspValid;
        return;
      end
    end
    errorCnt++;
    endSim();
  endtask : waitResp

  task automatic checkRsp(logic [3:0] opc, logic [7:0] a, output logic [31:0] f);
    logic got;
    f[31:8] = {nodeNumber, opc, memAt(a + 8'h01), memAt(a)};
    f[7:0] = crcOf({f[31:8], 8'h00}, rPoly);
    waitResp(got);
    check(got, 1'b1);
    check(rspMsg, f[31:8]);
    check(rspCrc, f[7:0]);
    check({rspCrcOk, rspSymErr}, 2'b10);
    check(busy, 1'b0);
  endtask : checkRsp

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic readScn(logic [7:0] a);
    logic [31:0] f;
    int nib;
    send({nodeNumber, OPC_READ, a, 8'h00});
    checkRsp(OPC_READ, a, f);
    check(chips.size(), 24);
    foreach (chips[k]) begin
      nib = f[31 - 4 * (k / 3) -: 4];
      check(chips[k], SYMS[nib * 3 + k % 3] - 8'h30);
    end
  endtask : readScn

  task automatic writeScn(logic [7:0] a, logic [7:0] d);
    logic [31:0] f;
    int i;
    send({nodeNumber, OPC_WRITE, a, d});
    for (i = 0; i < 400 && wrStb !== 1'b1; i++) @(negedge clk);
    check({wrStb, busy, regAddr, wrData}, {1'b1, 1'b1, a, d});
    check(regAddrNext, 8'(a + 8'h01));
    if (i == 400) endSim();
    else checkRsp(OPC_WRITE, a, f);
  endtask : writeScn

  task automatic ignoreScn();
    logic got;
    for (int v = 0; v < 16; v++) begin
      send({nodeNumber, 4'(v), 8'h40, 8'h00});
      waitResp(got);
      check(got, v == 0 || v == 8);
      send({4'(v), OPC_READ, 8'h40, 8'h00});
      waitResp(got);
      check(got, 4'(v) == nodeNumber);
      check(chips.size(), 4'(v) == nodeNumber ? 24 : 0);
    end
  endtask : ignoreScn

  task automatic dropScn();
    logic [23:0] m;
    logic        bad;
    logic        got;
    int          i;
    m = {nodeNumber, OPC_READ, 8'h10, 8'h00};
    sPoly = 8'h1D;
    bad = crcOf({m, crcOf({m, 8'h00}, mPoly)}, sPoly) != 8'h00;
    send(m);
    for (i = 0; i < 400 && cmdDrop !== 1'b1; i++) @(negedge clk);
    check(i < 400, bad);
    waitResp(got);
    check(got, !bad);
    sPoly = mPoly;
  endtask : dropScn

  task automatic fillScn();
    logic [31:0] f;
    int n;
    n = 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      cmdMsg = {nodeNumber, OPC_READ, 8'(n * 16), 8'h00};
      cmdValid = 1'b1;
      if (cmdReady === 1'b1) n++;
    end
    @(negedge clk);
    cmdValid = 1'b0;
    check(n, 9);
    for (int j = 0; j < n; j++) checkRsp(OPC_READ, 8'(j * 16), f);
  endtask : fillScn

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    nodeNumber = 4'h5;
    mPoly = 8'h2F;
    sPoly = 8'h2F;
    rPoly = 8'h2F;
    cmdMsg = 24'h000000;
    cmdValid = 1'b0;
    errorCnt = 0;
    comparisons = 0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    readScn(8'h3C);
    writeScn(8'h21, 8'hA7);
    ignoreScn();
    dropScn();
    mPoly = 8'h07;
    sPoly = 8'h07;
    rPoly = 8'h9B;
    readScn(8'hFF);
    fillScn();
    endSim();
  end
endmodule : dsi3_crm_frame_codec_tb
